/* File: ddr_psram_bus_protocol_test.sv */
// Self-checking bench for the memory-side bus engine driven by the host model.
// Assumes the wake counts are shortened to WAKE cycles through parameters.
module ddr_psram_bus_protocol_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam integer WAKE = 50;
    reg ref_clk = 1'b0;
    reg rst_b = 1'b0;
    reg extra_latency = 1'b0;
    wire host_clk, select_b, dq_oe, strobe, read_write_strobe_out, read_write_strobe_oe;
    wire hybrid_sleep, lowest_power_state;
    wire [7:0] dq_in, dq_out;
    integer error_cnt = 0;
    integer n_checks = 0;
    dpsb_slave #(.HS_WAKE_CYC(WAKE), .PD_WAKE_CYC(WAKE)) dpsb_slave_inst (
        .ref_clk(ref_clk), .rst_b(rst_b), .host_clk(host_clk), .select_b(select_b),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .read_write_strobe_in(strobe),
        .read_write_strobe_out(read_write_strobe_out),
        .read_write_strobe_oe(read_write_strobe_oe), .extra_latency(extra_latency),
        .hybrid_sleep(hybrid_sleep), .lowest_power_state(lowest_power_state)
    );
    dpsb_host_model dpsb_host_model_inst (
        .ref_clk(ref_clk), .slave_oe(read_write_strobe_oe), .slave_out(read_write_strobe_out),
        .host_clk(host_clk), .select_b(select_b), .dq_in(dq_in), .strobe(strobe)
    );
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    function automatic bit ck(input bit bad);
        n_checks = n_checks + 1;
        return bad;
    endfunction
    task err(input string m);
        begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task test_done;
        begin
            $display("Checks %0d, errors %0d", n_checks, error_cnt);
            if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    // Command word: kind, linear burst, upper column bits, reserved, lower column bits.
    function automatic [47:0] ca_word(input [1:0] kind, input [31:0] addr);
        return {kind, 1'b0, addr[31:3], 13'h0000, addr[2:0]};
    endfunction
    task rd(input [31:0] addr, input integer le, input [31:0] ex);
        integer i;
        begin
            dpsb_host_model_inst.start(ca_word(2'h2, addr));
            dpsb_host_model_inst.lat(le, 1'b0);
            for (i = 0; i < 4; i = i + 1) begin
                dpsb_host_model_inst.tick(8'h00);
                if (ck(dq_out !== ex[31 - 8 * i -: 8])) err("read byte mismatch");
                if (ck(read_write_strobe_out !== ~i[0] || dq_oe !== 1'b1)) err("bad strobe");
            end
            dpsb_host_model_inst.stop;
        end
    endtask
    task wr(input [31:0] addr, input [31:0] d, input [3:0] m);
        integer i;
        begin
            dpsb_host_model_inst.start(ca_word(2'h0, addr));
            dpsb_host_model_inst.lat(12, 1'b1);
            for (i = 0; i < 4; i = i + 1) dpsb_host_model_inst.wbyte(d[31 - 8 * i -: 8], m[3 - i]);
            dpsb_host_model_inst.stop;
        end
    endtask
    task regwr(input [31:0] addr, input [15:0] d);
        begin
            dpsb_host_model_inst.start(ca_word(2'h1, addr));
            dpsb_host_model_inst.tick(d[15:8]);
            dpsb_host_model_inst.tick(d[7:0]);
            dpsb_host_model_inst.stop;
        end
    endtask
    task wait_flag(input bit lp, input bit want, input integer lim);
        integer n;
        begin
            n = 0;
            while ((lp ? lowest_power_state : hybrid_sleep) !== want && n < lim) begin
                @(negedge ref_clk);
                n = n + 1;
            end
        end
    endtask
    task t_mask;
        begin
            wr(32'h00000003, 32'hA1B2C3D4, 4'h0);
            wr(32'h00000003, 32'h11223344, 4'h9);
            rd(32'h00000003, 12, 32'hA12233D4);
        end
    endtask
    task t_extra;
        begin
            extra_latency = 1'b1;
            rd(32'h00000003, 24, 32'hA12233D4);
            extra_latency = 1'b0;
        end
    endtask
    task t_hybrid;
        begin
            regwr(32'h00000801, 16'hFFE1);
            wait_flag(1'b0, 1'b1, 740);
            if (ck(hybrid_sleep !== 1'b1)) err("hybrid sleep not reached");
            dpsb_host_model_inst.pulse(200);
            wait_flag(1'b0, 1'b0, WAKE + 10);
            if (ck(hybrid_sleep !== 1'b0)) err("hybrid sleep not left");
            repeat (WAKE) @(negedge ref_clk);
            rd(32'h00000003, 12, 32'hA12233D4);
        end
    endtask
    task t_deep;
        begin
            regwr(32'h00000800, 16'h0F1F);
            wait_flag(1'b1, 1'b1, 740);
            if (ck(lowest_power_state !== 1'b1)) err("lowest power not reached");
            dpsb_host_model_inst.pulse(100);
            repeat (WAKE + 20) @(negedge ref_clk);
            if (ck(lowest_power_state !== 1'b1)) err("short pulse woke device");
            dpsb_host_model_inst.pulse(400);
            wait_flag(1'b1, 1'b0, WAKE + 10);
            if (ck(lowest_power_state !== 1'b0)) err("lowest power not left");
        end
    endtask
    initial begin
        repeat (6) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge ref_clk);
        t_mask;
        t_extra;
        t_hybrid;
        t_deep;
        test_done;
    end
    initial begin
        #60000;
        err("watchdog expired");
        test_done;
    end
endmodule // ddr_psram_bus_protocol_test

/* File: dpsb_defines.vh */
// Constants for the double-data-rate pseudo-static memory bus slave.
// Assumes a 250 MHz ref_clk (4 ns) that oversamples the host clock.
`ifndef DPSB_DEFINES_VH
`define DPSB_DEFINES_VH
`define DPSB_CLK_PERIOD_NS 4
`define DPSB_CA_BYTES 6
`define DPSB_LAT_CYCLES 6
`define DPSB_ENTER_US 3
`define DPSB_HS_EXIT_MIN_NS 60
`define DPSB_HS_EXIT_MAX_NS 3000
`define DPSB_HS_WAKE_US 100
`define DPSB_PD_EXIT_MIN_NS 200
`define DPSB_PD_EXIT_MAX_NS 3000
`define DPSB_PD_WAKE_US 150
`define DPSB_CA_RD_BIT 47
`define DPSB_CA_REG_BIT 46
`define DPSB_CR0_ADDR 32'h00000800
`define DPSB_CR1_ADDR 32'h00000801
`define DPSB_CR0_PD_BIT 15
`define DPSB_CR1_HS_BIT 5
`define DPSB_CR0_RESET 16'h8F1F
`define DPSB_CR1_RESET 16'hFFC1
`endif

/* File: dpsb_host_model.sv */
// Host master model: drives host clock, select, data and the write mask strobe.
// Assumes ref_clk runs free; every host pin changes on a ref_clk falling edge.
module dpsb_host_model (
    input wire ref_clk,
    input wire slave_oe,
    input wire slave_out,
    output reg host_clk,
    output reg select_b,
    output wire [7:0] dq_in,
    output wire strobe
);
    timeunit 1ns;
    timeprecision 100ps;
    reg flip_q = 1'b0;
    reg dq_oe_q = 1'b0;
    reg rw_oe_q = 1'b0;
    reg rw_q = 1'b0;
    reg [7:0] dq_q = 8'h00;
    realtime t_q = 0.0;
    initial begin
        host_clk = 1'b0;
        select_b = 1'b1;
    end
    always @(negedge ref_clk) flip_q <= ~flip_q;
    // Released lines carry a moving pattern, so a stale level never passes for data.
    assign dq_in = dq_oe_q ? dq_q : {8{flip_q}};
    assign strobe = slave_oe ? slave_out : (rw_oe_q ? rw_q : flip_q);
    // The 62.5 ns half period holds on average; each change still lands on a falling edge.
    task half;
        begin
            t_q = t_q + 62.5;
            while ($realtime < t_q) @(negedge ref_clk);
        end
    endtask
    task tick(input [7:0] b);
        begin
            dq_q = b;
            host_clk = ~host_clk;
            half;
        end
    endtask
    task start(input [47:0] ca);
        integer i;
        begin
            @(negedge ref_clk);
            t_q = $realtime;
            select_b = 1'b0;
            dq_oe_q = 1'b1;
            half;
            for (i = 0; i < 6; i = i + 1) tick(ca[47 - 8 * i -: 8]);
        end
    endtask
    task lat(input integer n, input wr);
        integer i;
        begin
            dq_oe_q = wr;
            for (i = 0; i < n; i = i + 1) begin
                if (wr && i == n - 2) begin
                    rw_oe_q = 1'b1;
                    rw_q = 1'b0;
                end
                tick(dq_q);
            end
        end
    endtask
    task wbyte(input [7:0] b, input m);
        begin
            rw_q = m;
            tick(b);
        end
    endtask
    task stop;
        begin
            select_b = 1'b1;
            dq_oe_q = 1'b0;
            rw_oe_q = 1'b0;
            repeat (20) @(negedge ref_clk);
        end
    endtask
    task pulse(input integer ns);
        begin
            @(negedge ref_clk);
            select_b = 1'b0;
            repeat (ns / 4) @(negedge ref_clk);
            select_b = 1'b1;
        end
    endtask
endmodule // dpsb_host_model

/* File: dpsb_slave.v */
// Memory-side bus protocol engine with a small flip-flop array and two config registers.
// Assumes the host keeps its own rules; all pins sampled by ref_clk.
// Contract
// - Memory alone drives the strobe throughout a read.
// - Strobe high in command phase means extra latency, else low.
// - Read data and strobe toggle edge-aligned on both clock edges.
// - Memory releases strobe after command phase of a latency write.
// - Strobe masks bytes in latency writes; masked bytes stay unchanged.
// - Memory drives strobe during every command phase, before decode.
// - Zero-latency writes ignore the strobe level; strobe held low.
// - Zero-latency writes store every byte, no masking.
// - Hybrid sleep reached within 3 us of second register bit 5 set.
// - Select pulse 60-3000 ns leaves hybrid sleep; standby within 100 us.
// - Lowest power reached within 3 us of first register bit 15 cleared.
// - Select pulse 200-3000 ns leaves lowest power; standby within 150 us.
`include "dpsb_defines.vh"
module dpsb_slave #(
    parameter DEPTH = 16,
    parameter AW = 4,
    parameter HS_WAKE_CYC = (`DPSB_HS_WAKE_US * 1000) / `DPSB_CLK_PERIOD_NS,
    parameter PD_WAKE_CYC = (`DPSB_PD_WAKE_US * 1000) / `DPSB_CLK_PERIOD_NS
) (
    input wire ref_clk,
    input wire rst_b,
    input wire host_clk,
    input wire select_b,
    input wire [7:0] dq_in,
    output reg [7:0] dq_out,
    output reg dq_oe,
    input wire read_write_strobe_in,
    output reg read_write_strobe_out,
    output reg read_write_strobe_oe,
    input wire extra_latency,
    output wire hybrid_sleep,
    output wire lowest_power_state
);
    localparam ST_IDLE = 6'h01;
    localparam ST_CA = 6'h02;
    localparam ST_LAT = 6'h04;
    localparam ST_RD = 6'h08;
    localparam ST_WR = 6'h10;
    localparam ST_DONE = 6'h20;
    localparam P_IDLE = 3'h1;
    localparam P_HS = 3'h2;
    localparam P_PD = 3'h4;
    localparam [15:0] ENTER_CYC = (`DPSB_ENTER_US * 1000) / `DPSB_CLK_PERIOD_NS;
    localparam [15:0] HS_MIN_CYC = (`DPSB_HS_EXIT_MIN_NS + `DPSB_CLK_PERIOD_NS - 1) /
        `DPSB_CLK_PERIOD_NS;
    localparam [15:0] HS_MAX_CYC = `DPSB_HS_EXIT_MAX_NS / `DPSB_CLK_PERIOD_NS;
    localparam [15:0] PD_MIN_CYC = (`DPSB_PD_EXIT_MIN_NS + `DPSB_CLK_PERIOD_NS - 1) /
        `DPSB_CLK_PERIOD_NS;
    localparam [15:0] PD_MAX_CYC = `DPSB_PD_EXIT_MAX_NS / `DPSB_CLK_PERIOD_NS;
    localparam [31:0] HS_WAKE = HS_WAKE_CYC;
    localparam [31:0] PD_WAKE = PD_WAKE_CYC;

    wire ck_lvl;
    wire ck_rise;
    wire ck_fall;
    wire cs_lvl;
    wire cs_rise;
    wire cs_fall;
    wire ck_edge = ck_rise | ck_fall;
    dpsb_sync u_ck (
        .clk(ref_clk),
        .rst_b(rst_b),
        .din(host_clk),
        .level(ck_lvl),
        .rise(ck_rise),
        .fall(ck_fall)
    );
    dpsb_sync #(
        .IDLE(1'b1)
    ) u_cs (
        .clk(ref_clk),
        .rst_b(rst_b),
        .din(select_b),
        .level(cs_lvl),
        .rise(cs_rise),
        .fall(cs_fall)
    );
    // Data pins are sampled through the same three-stage depth so they line up with clock edges.
    reg [7:0] dq1_q;
    reg [7:0] dq2_q;
    reg [7:0] dq3_q;
    reg ds1_q;
    reg ds2_q;
    reg ds3_q;
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dq1_q <= 8'h00;
            dq2_q <= 8'h00;
            dq3_q <= 8'h00;
            ds1_q <= 1'b0;
            ds2_q <= 1'b0;
            ds3_q <= 1'b0;
        end else begin
            dq1_q <= dq_in;
            dq2_q <= dq1_q;
            dq3_q <= dq2_q;
            ds1_q <= read_write_strobe_in;
            ds2_q <= ds1_q;
            ds3_q <= ds2_q;
        end
    end

    reg [5:0] st_q;
    reg [2:0] pw_q;
    reg [47:0] ca_q;
    reg [3:0] cnt_q;
    reg [7:0] lat_q;
    reg lat2_q;
    reg hi_q;
    reg [7:0] hold_q;
    reg [AW-1:0] idx_q;
    reg [15:0] mem_q [0:DEPTH-1];
    reg [15:0] cr0_q;
    reg [15:0] cr1_q;
    reg [15:0] ent_q;
    reg ent_pd_q;
    reg ent_hs_q;
    reg [15:0] pls_q;
    reg [31:0] wake_q;
    integer i;

    function [47:0] ca_shift;
        input [47:0] ca;
        input [7:0] b;
        begin
            ca_shift = {ca[39:0], b};
        end
    endfunction

    // Index from the lower column bits XORed with reserved bits AW+2 to 3; the upper column bits take no part.
    wire [AW-1:0] ca_idx = ca_q[AW+2:3] ^ {{(AW-3){1'b0}}, ca_q[2:0]};
    wire is_rd = ca_q[`DPSB_CA_RD_BIT];
    wire is_reg = ca_q[`DPSB_CA_REG_BIT];
    wire [31:0] reg_addr = {ca_q[44:16], ca_q[2:0]};
    wire asleep = ~pw_q[0];
    assign hybrid_sleep = pw_q[1];
    assign lowest_power_state = pw_q[2];

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= ST_IDLE;
            ca_q <= 48'h000000000000;
            cnt_q <= 4'h0;
            lat_q <= 8'h00;
            lat2_q <= 1'b0;
            hi_q <= 1'b0;
            hold_q <= 8'h00;
            idx_q <= {AW{1'b0}};
            cr0_q <= `DPSB_CR0_RESET;
            cr1_q <= `DPSB_CR1_RESET;
            dq_out <= 8'h00;
            dq_oe <= 1'b0;
            read_write_strobe_out <= 1'b0;
            read_write_strobe_oe <= 1'b0;
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_q[i] <= 16'h0000;
            end
        end else if (cs_lvl | asleep) begin
            // Select high ends any transaction and releases both lines.
            st_q <= ST_IDLE;
            dq_oe <= 1'b0;
            read_write_strobe_oe <= 1'b0;
            read_write_strobe_out <= 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    read_write_strobe_oe <= 1'b1;
                    read_write_strobe_out <= extra_latency;
                    lat2_q <= extra_latency;
                    cnt_q <= 4'h0;
                    st_q <= ST_CA;
                end
                ST_CA: begin
                    if (ck_edge) begin
                        ca_q <= ca_shift(ca_q, dq3_q);
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == `DPSB_CA_BYTES - 1) begin
                            st_q <= ST_LAT;
                            lat_q <= 8'h00;
                            hi_q <= 1'b0;
                        end
                    end
                end
                ST_LAT: begin
                    idx_q <= ca_idx;
                    if (!is_rd && is_reg) begin
                        read_write_strobe_out <= 1'b0;
                        st_q <= ST_WR;
                    end else begin
                        read_write_strobe_oe <= is_rd;
                        read_write_strobe_out <= 1'b0;
                        if (ck_edge) begin
                            lat_q <= lat_q + 8'h01;
                            if (lat_q == (lat2_q ? 4 : 2) * `DPSB_LAT_CYCLES - 1) begin
                                st_q <= is_rd ? ST_RD : ST_WR;
                            end
                        end
                    end
                end
                ST_RD: begin
                    read_write_strobe_oe <= 1'b1;
                    dq_oe <= 1'b1;
                    if (ck_edge) begin
                        dq_out <= hi_q ? mem_q[idx_q][7:0] : mem_q[idx_q][15:8];
                        read_write_strobe_out <= ~hi_q;
                        hi_q <= ~hi_q;
                        if (hi_q) begin
                            idx_q <= idx_q + {{(AW-1){1'b0}}, 1'b1};
                        end
                    end
                end
                ST_WR: begin
                    if (ck_edge) begin
                        hi_q <= ~hi_q;
                        if (!hi_q) begin
                            hold_q <= dq3_q;
                            lat2_q <= ds3_q;
                        end else if (is_reg) begin
                            if (reg_addr == `DPSB_CR0_ADDR) begin
                                cr0_q <= {hold_q, dq3_q};
                            end
                            if (reg_addr == `DPSB_CR1_ADDR) begin
                                cr1_q <= {hold_q, dq3_q};
                            end
                        end else begin
                            if (!lat2_q) begin
                                mem_q[idx_q][15:8] <= hold_q;
                            end
                            if (!ds3_q) begin
                                mem_q[idx_q][7:0] <= dq3_q;
                            end
                            idx_q <= idx_q + {{(AW-1){1'b0}}, 1'b1};
                        end
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Power state: entry timer after any select rise with a sleep request set in the config registers, pulse width and wakeup on exit.
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pw_q <= P_IDLE;
            ent_q <= 16'h0000;
            ent_pd_q <= 1'b0;
            ent_hs_q <= 1'b0;
            pls_q <= 16'h0000;
            wake_q <= 32'h00000000;
        end else begin
            case (pw_q)
                P_IDLE: begin
                    if (wake_q != 32'h00000000) begin
                        wake_q <= wake_q - 32'h00000001;
                    end
                    if (cs_rise && !cr0_q[`DPSB_CR0_PD_BIT]) begin
                        ent_pd_q <= 1'b1;
                        ent_q <= 16'h0000;
                    end else if (cs_rise && cr1_q[`DPSB_CR1_HS_BIT]) begin
                        ent_hs_q <= 1'b1;
                        ent_q <= 16'h0000;
                    end else if (ent_pd_q | ent_hs_q) begin
                        ent_q <= ent_q + 16'h0001;
                        if (ent_pd_q && ent_q == ENTER_CYC - 16'h0001) begin
                            pw_q <= P_PD;
                            ent_pd_q <= 1'b0;
                            ent_hs_q <= 1'b0;
                        end else if (ent_hs_q && ent_q == ENTER_CYC - 16'h0001) begin
                            pw_q <= P_HS;
                            ent_hs_q <= 1'b0;
                        end
                    end
                end
                P_HS, P_PD: begin
                    pls_q <= cs_lvl ? 16'h0000 : pls_q + 16'h0001;
                    if (cs_rise) begin
                        if (pw_q[1] && pls_q >= HS_MIN_CYC && pls_q <= HS_MAX_CYC) begin
                            wake_q <= HS_WAKE;
                            pw_q <= P_IDLE;
                        end else if (pw_q[2] && pls_q >= PD_MIN_CYC &&
                                pls_q <= PD_MAX_CYC) begin
                            wake_q <= PD_WAKE;
                            pw_q <= P_IDLE;
                        end
                    end
                end
                default: begin
                    pw_q <= P_IDLE;
                end
            endcase
        end
    end
endmodule // dpsb_slave

/* File: dpsb_slave_asserts.sv */
// Concurrent checks on the memory-side bus engine, bound into dpsb_slave.
// Assumes host pins change away from ref_clk rising edges.
module dpsb_slave_asserts (
    input wire ref_clk,
    input wire rst_b,
    input wire host_clk,
    input wire select_b,
    input wire [7:0] dq_in,
    input wire [7:0] dq_out,
    input wire dq_oe,
    input wire read_write_strobe_in,
    input wire read_write_strobe_out,
    input wire read_write_strobe_oe,
    input wire extra_latency,
    input wire hybrid_sleep,
    input wire lowest_power_state
);
    reg hc_q;
    reg [5:0] edge_q;
    reg [7:0] first_q;
    wire asleep = hybrid_sleep || lowest_power_state;
    // Pin edges are counted here so the checks know the transaction kind without the body.
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            hc_q <= 1'b0;
            edge_q <= 6'h00;
            first_q <= 8'h00;
        end else begin
            hc_q <= host_clk;
            if (select_b) begin
                edge_q <= 6'h00;
            end else if (host_clk != hc_q && edge_q != 6'h3F) begin
                edge_q <= edge_q + 6'h01;
                if (edge_q == 6'h00) begin
                    first_q <= dq_in;
                end
            end
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    sequence sel_start;
        $fell(select_b) && !asleep;
    endsequence
    sequence strobe_up;
        ##[1:6] read_write_strobe_oe;
    endsequence
    sequence ca_level;
        (read_write_strobe_out == extra_latency) [*8];
    endsequence
    AST_CA_DRIVE: assert property (sel_start |-> strobe_up)
        else $error("strobe not driven in command phase");
    AST_LAT_LEVEL: assert property ($rose(read_write_strobe_oe) |-> ca_level)
        else $error("command phase strobe level differs from latency");
    AST_RELEASE: assert property ($rose(select_b) |-> ##[1:6] (!read_write_strobe_oe && !dq_oe))
        else $error("lines still driven after select high");
    AST_READ_OWNS: assert property (dq_oe |-> read_write_strobe_oe)
        else $error("read data without strobe");
    AST_READ_DRIVE: assert property ((edge_q != 6'h00 && first_q[7] && !select_b)
        |-> read_write_strobe_oe)
        else $error("strobe released during read");
    AST_EDGE_ALIGN: assert property ((dq_oe && $past(dq_oe) && dq_out != $past(dq_out))
        |-> read_write_strobe_out != $past(read_write_strobe_out))
        else $error("data changed without strobe edge");
    AST_WR_RELEASE: assert property ((edge_q >= 6'h07 && first_q[7:6] == 2'h0)
        |-> !read_write_strobe_oe)
        else $error("strobe kept after command phase of write");
    AST_ZL_STROBE: assert property ((edge_q >= 6'h07 && first_q[7:6] == 2'h1)
        |-> (!read_write_strobe_oe || !read_write_strobe_out))
        else $error("strobe driven high in register write");
    AST_SLEEP_QUIET: assert property (asleep |-> (!dq_oe && !read_write_strobe_oe))
        else $error("lines driven while asleep");
endmodule // dpsb_slave_asserts
bind dpsb_slave dpsb_slave_asserts dpsb_slave_asserts_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .host_clk(host_clk), .select_b(select_b),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .read_write_strobe_in(read_write_strobe_in),
    .read_write_strobe_out(read_write_strobe_out), .read_write_strobe_oe(read_write_strobe_oe),
    .extra_latency(extra_latency), .hybrid_sleep(hybrid_sleep),
    .lowest_power_state(lowest_power_state)
);

/* File: dpsb_sync.v */
// Three-stage synchroniser for one pin input, with edge report.
// Assumes the input is asynchronous to clk; the first stage feeds only the second.
module dpsb_sync #(
    parameter IDLE = 1'b0
) (
    input wire clk,
    input wire rst_b,
    input wire din,
    output wire level,
    output wire rise,
    output wire fall
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    reg s4_q;
    // Stages reset to the pin's idle level, so no false edge follows reset.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= IDLE;
            s2_q <= IDLE;
            s3_q <= IDLE;
            s4_q <= IDLE;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            s4_q <= s3_q;
        end
    end
    // A change counts once the third and fourth stages differ, so edges are taken at the third.
    assign level = s3_q;
    assign rise = s3_q & ~s4_q;
    assign fall = ~s3_q & s4_q;
endmodule // dpsb_sync
